// ### src/cdo_consts.vh
`ifndef CDO_CONSTS_VH
`define CDO_CONSTS_VH

// register addresses
`define CDO_A_PWR        16'h0400
`define CDO_A_ENA        16'h0401
`define CDO_A_SYNC       16'h0402
`define CDO_A_AUTO       16'h0403
`define CDO_A_MODE0      16'h0404
`define CDO_A_MODE3      16'h0407
`define CDO_A_DIV0       16'h0408
`define CDO_A_DIVL       16'h0417
`define CDO_A_STAT       16'h04F0
`define CDO_A_CMD        16'h04F1

// widths
`define CDO_DIV_W        30
`define CDO_DIV_TOP_W    6
`define CDO_NCH          4
`define CDO_DIV_STRIDE   4
`define CDO_DIV_CH0      2'h2
`define CDO_MODE_RSV     2'h3

// field positions
`define CDO_PWR_EXTR     5
`define CDO_PWR_RXHF     4
`define CDO_SRC_HI       5
`define CDO_SRC_LO       4
`define CDO_MODE_CPH     5
`define CDO_MODE_POL     4
`define CDO_MODE_DRV     3
`define CDO_CMD_SYNC     0

// codes
`define CDO_SRC_DIRECT   2'h0
`define CDO_SRC_REF      2'h1
`define CDO_SRC_FB       2'h2
`define CDO_SRC_RSV      2'h3
`define CDO_AUTO_OFF     2'h0
`define CDO_AUTO_FREQ    2'h1
`define CDO_AUTO_PHASE   2'h2
`define CDO_AUTO_RSV     2'h3
`define CDO_MODE_CMOS2   3'h0
`define CDO_MODE_CMOSP   3'h1
`define CDO_MODE_CMOSN   3'h2
`define CDO_MODE_TRI     3'h3
`define CDO_MODE_LVDS    3'h4
`define CDO_MODE_LVPECL  3'h5

// reset values
`define CDO_PWR_RST      6'h00
`define CDO_ENA_RST      4'h0
`define CDO_SYNC_RST     6'h00
`define CDO_AUTO_RST     2'h0
`define CDO_MODE_RST     6'h03
`define CDO_DIV_RST      30'h00000000
`define CDO_ALL_DOWN     4'hF

`endif

// ### src/cdo_chan_div.v
`timescale 1ns/100ps
`include "cdo_consts.vh"

// one channel divider: output toggles after max(ratio,1) clock cycles
module cdo_chan_div (
   input  wire                   clk,
   input  wire                   rst_n,
   input  wire [`CDO_DIV_W-1:0]  ratio,
   input  wire                   run,
   input  wire                   sync,
   output reg                    clk_q
);

   reg  [`CDO_DIV_W-1:0] cnt_q;
   wire [`CDO_DIV_W-1:0] last;

   // zero behaves as divide by one
   assign last = (ratio == `CDO_DIV_RST) ? `CDO_DIV_RST : ratio - 30'h00000001; // RULE_14

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= `CDO_DIV_RST;
         clk_q <= 1'b0;
      end else if (sync || !run) begin
         cnt_q <= `CDO_DIV_RST; // RULE_15
         clk_q <= 1'b0;
      end else if (cnt_q >= last) begin
         cnt_q <= `CDO_DIV_RST;
         clk_q <= ~clk_q;
      end else begin
         cnt_q <= cnt_q + 30'h00000001;
      end
   end

endmodule // cdo_chan_div

// ### src/cdo_dist_top.v
//
// Summary of operation
// RULE_01 - settings bit 5 picks internal (0) or external (1) current resistor.
// RULE_02 - settings bit 4 picks normal (0) or super-Nyquist (1) receiver mode.
// RULE_03 - settings bits 3..0 power down channels 3..0 when set; reset zero.
// RULE_04 - all four power-down bits set puts distribution into deep sleep.
// RULE_05 - enable register bits 3..0 enable channel drivers; reset disabled.
// RULE_06 - sync source 00 direct, 01 active reference, 10 loop feedback; 11 reserved.
// RULE_07 - sync register bits 3..0 mask divider sync reset per channel.
// RULE_08 - autosync 00 off, 01 on frequency lock, 10 on phase lock.
// RULE_09 - mode bit 5 inverts relative CMOS pin phase; no effect otherwise.
// RULE_10 - mode bit 4 inverts channel output polarity; reset not inverted.
// RULE_11 - mode bit 3 selects high drive; reset gives low drive.
// RULE_12 - mode field picks CMOS pin use, tristate, LVDS or LVPECL.
// RULE_13 - channels one to three have mode registers at following addresses.
// RULE_14 - each channel divider is 30 bits; zero means divide by one.
// RULE_15 - armed autosync issues one sync per lock rise, aligned to source.
// RULE_16 - software never writes reserved codes; such writes leave field unchanged.
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
`include "cdo_consts.vh"

module cdo_dist_top (
   input  wire        CLK_SYS,
   input  wire        RESET_N,
   input  wire [15:0] REG_ADDR,
   input  wire [7:0]  REG_WDATA,
   input  wire        REG_WR,
   input  wire        REG_RD,
   output reg  [7:0]  REG_RDATA,
   input  wire        LOOP_FREQ_LOCK,
   input  wire        LOOP_PHASE_LOCK,
   input  wire        REF_ACTIVE_EDGE,
   input  wire        LOOP_FB_EDGE,
   output reg  [3:0]  CH_P_OUT,
   output reg  [3:0]  CH_P_OE,
   output reg  [3:0]  CH_N_OUT,
   output reg  [3:0]  CH_N_OE,
   output reg  [3:0]  CH_PWRDN,
   output reg  [3:0]  CH_DRIVE_HI,
   output reg  [3:0]  CH_LVDS,
   output reg  [3:0]  CH_LVPECL,
   output reg         DIST_EXT_RSET,
   output reg         DIST_RX_HF,
   output reg         DIST_DEEP_SLEEP,
   output reg  [3:0]  DIV_SYNC
);

   reg  [5:0]   pwr_q;
   reg  [3:0]   ena_q;
   reg  [5:0]   sync_q;
   reg  [1:0]   auto_q;
   reg          freq_q;
   reg          phase_q;
   reg          pend_q;
   reg  [3:0]   div_sync_q;
   reg  [7:0]   rdata_d;
   reg  [29:0]  rd_div;
   reg  [5:0]   rd_mode;
   reg          fire;

   wire [23:0]  mode_all;
   wire [119:0] div_all;
   wire [3:0]   dclk;
   wire [3:0]   p_d;
   wire [3:0]   poe_d;
   wire [3:0]   n_d;
   wire [3:0]   noe_d;
   wire [3:0]   lvds_d;
   wire [3:0]   lvpecl_d;
   wire [3:0]   drv_d;
   wire [3:0]   run;
   wire         deep;
   wire         f_rise;
   wire         p_rise;
   wire         auto_req;
   wire         man_req;
   wire         req;
   wire [1:0]   src;
   wire [1:0]   rd_ch;
   wire         in_mode;
   wire         in_div;

   // deep sleep once every channel is powered down
   assign deep = (pwr_q[3:0] == `CDO_ALL_DOWN); // RULE_04
   assign src  = sync_q[`CDO_SRC_HI:`CDO_SRC_LO];

   // global control registers
   always @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         pwr_q  <= `CDO_PWR_RST;
         ena_q  <= `CDO_ENA_RST;
         sync_q <= `CDO_SYNC_RST;
         auto_q <= `CDO_AUTO_RST;
      end else if (REG_WR) begin
         if (REG_ADDR == `CDO_A_PWR) begin
            pwr_q <= REG_WDATA[5:0]; // RULE_01 RULE_02 RULE_03
         end else if (REG_ADDR == `CDO_A_ENA) begin
            ena_q <= REG_WDATA[3:0]; // RULE_05
         end else if (REG_ADDR == `CDO_A_SYNC) begin
            sync_q[3:0] <= REG_WDATA[3:0]; // RULE_07
            // a reserved source code is dropped, the mask bits still land
            if (REG_WDATA[`CDO_SRC_HI:`CDO_SRC_LO] != `CDO_SRC_RSV) begin
               sync_q[5:4] <= REG_WDATA[`CDO_SRC_HI:`CDO_SRC_LO]; // RULE_06 RULE_16
            end
         end else if (REG_ADDR == `CDO_A_AUTO) begin
            // a reserved autosync code keeps the mode in force
            if (REG_WDATA[1:0] != `CDO_AUTO_RSV) begin
               auto_q <= REG_WDATA[1:0]; // RULE_08 RULE_16
            end
         end
      end
   end

   // divider synchronization
   // a lock rise is the level now against the level one cycle ago
   assign f_rise   = LOOP_FREQ_LOCK & ~freq_q;
   assign p_rise   = LOOP_PHASE_LOCK & ~phase_q;
   assign auto_req = ((auto_q == `CDO_AUTO_FREQ) & f_rise) |
                     ((auto_q == `CDO_AUTO_PHASE) & p_rise); // RULE_08 RULE_15
   // software asks for a sync through the command register
   assign man_req  = REG_WR & (REG_ADDR == `CDO_A_CMD) & REG_WDATA[`CDO_CMD_SYNC];
   assign req      = auto_req | man_req;

   // a pending request waits for the edge chosen by the sync source
   always @* begin
      case (src)
         `CDO_SRC_DIRECT: fire = pend_q;
         `CDO_SRC_REF:    fire = pend_q & REF_ACTIVE_EDGE; // RULE_06
         `CDO_SRC_FB:     fire = pend_q & LOOP_FB_EDGE;
         // the reserved source code is never stored
         default:         fire = 1'b0;
      endcase
   end

   always @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         freq_q     <= 1'b0;
         phase_q    <= 1'b0;
         pend_q     <= 1'b0;
         div_sync_q <= 4'h0;
      end else begin
         freq_q  <= LOOP_FREQ_LOCK;
         phase_q <= LOOP_PHASE_LOCK;
         // a new request in the firing cycle stays pending
         pend_q  <= (pend_q & ~fire) | req; // RULE_15
         // masked channels get no clear; the clear lasts one cycle
         if (fire) begin
            div_sync_q <= ~sync_q[3:0]; // RULE_07 RULE_15
         end else begin
            div_sync_q <= 4'h0;
         end
      end
   end

   // per-channel mode, divider, and pin logic
   genvar g;
   generate
      for (g = 0; g < `CDO_NCH; g = g + 1) begin : ch
         // mode register and divider byte addresses of this channel
         localparam [15:0] MA = `CDO_A_MODE0 + g;
         localparam [15:0] DA = `CDO_A_DIV0 + `CDO_DIV_STRIDE * g;

         reg  [5:0]  mode_q;
         reg  [29:0] div_q;
         reg         p_c;
         reg         n_c;
         reg         poe_c;
         reg         noe_c;
         wire        base;
         wire        on;
         wire        cph;
         wire [2:0]  pin_mode;

         always @(posedge CLK_SYS or negedge RESET_N) begin
            if (!RESET_N) begin
               mode_q <= `CDO_MODE_RST;
               div_q  <= `CDO_DIV_RST;
            end else if (REG_WR) begin
               if (REG_ADDR == MA) begin // RULE_13
                  // bits 5:3 always land; a reserved pin code keeps the old one
                  mode_q[5:3] <= REG_WDATA[5:3];
                  if (REG_WDATA[2:1] != `CDO_MODE_RSV) begin
                     mode_q[2:0] <= REG_WDATA[2:0]; // RULE_12 RULE_16
                  end
               end else if (REG_ADDR[15:2] == DA[15:2]) begin
                  // divider bytes land one at a time, with no shadow copy
                  if (REG_ADDR[1:0] == 2'h0) begin
                     div_q[7:0] <= REG_WDATA;
                  end else if (REG_ADDR[1:0] == 2'h1) begin
                     div_q[15:8] <= REG_WDATA;
                  end else if (REG_ADDR[1:0] == 2'h2) begin
                     div_q[23:16] <= REG_WDATA;
                  end else begin
                     div_q[29:24] <= REG_WDATA[`CDO_DIV_TOP_W-1:0]; // RULE_14
                  end
               end
            end
         end

         assign mode_all[6*g +: 6]   = mode_q;
         assign div_all[30*g +: 30]  = div_q;
         // a channel runs only while enabled and not powered down
         assign run[g] = ena_q[g] & ~pwr_q[g] & ~deep; // RULE_03 RULE_04 RULE_05
         assign pin_mode = mode_q[2:0];

         // the divider is held at zero while its channel is stopped
         cdo_chan_div u_div (
            .clk   (CLK_SYS),
            .rst_n (RESET_N),
            .ratio (div_q),
            .run   (run[g]),
            .sync  (div_sync_q[g]),
            .clk_q (dclk[g])
         );

         // polarity acts on both pins, phase invert only on the CMOS pair
         assign base = dclk[g] ^ mode_q[`CDO_MODE_POL]; // RULE_10
         assign cph  = mode_q[`CDO_MODE_CPH];
         assign on   = run[g];

         always @* begin
            p_c   = base;
            n_c   = ~base;
            poe_c = 1'b0;
            noe_c = 1'b0;
            case (pin_mode)
               `CDO_MODE_CMOS2: begin
                  n_c   = cph ? base : ~base; // RULE_09
                  poe_c = 1'b1;
                  noe_c = 1'b1;
               end
               `CDO_MODE_CMOSP: begin
                  poe_c = 1'b1; // RULE_12
               end
               `CDO_MODE_CMOSN: begin
                  noe_c = 1'b1;
               end
               `CDO_MODE_LVDS, `CDO_MODE_LVPECL: begin
                  poe_c = 1'b1; // RULE_09
                  noe_c = 1'b1;
               end
               default: begin
                  poe_c = 1'b0;
                  noe_c = 1'b0;
               end
            endcase
         end

         // an undriven pin is held low so a load never sees a stale toggle
         assign p_d[g]      = on & poe_c & p_c; // RULE_12
         assign n_d[g]      = on & noe_c & n_c;
         assign poe_d[g]    = on & poe_c;
         assign noe_d[g]    = on & noe_c;
         // mode flags for the analog driver
         assign lvds_d[g]   = (pin_mode == `CDO_MODE_LVDS); // RULE_12
         assign lvpecl_d[g] = (pin_mode == `CDO_MODE_LVPECL);
         assign drv_d[g]    = mode_q[`CDO_MODE_DRV]; // RULE_11
      end
   endgenerate

   // registered outputs
   // pins lag the divider by one cycle
   always @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         CH_P_OUT        <= 4'h0;
         CH_P_OE         <= 4'h0;
         CH_N_OUT        <= 4'h0;
         CH_N_OE         <= 4'h0;
         CH_PWRDN        <= 4'h0;
         CH_DRIVE_HI     <= 4'h0;
         CH_LVDS         <= 4'h0;
         CH_LVPECL       <= 4'h0;
         DIST_EXT_RSET   <= 1'b0;
         DIST_RX_HF      <= 1'b0;
         DIST_DEEP_SLEEP <= 1'b0;
         DIV_SYNC        <= 4'h0;
      end else begin
         CH_P_OUT        <= p_d;
         CH_P_OE         <= poe_d;
         CH_N_OUT        <= n_d;
         CH_N_OE         <= noe_d;
         CH_PWRDN        <= pwr_q[3:0]; // RULE_03
         CH_DRIVE_HI     <= drv_d; // RULE_11
         CH_LVDS         <= lvds_d;
         CH_LVPECL       <= lvpecl_d;
         DIST_EXT_RSET   <= pwr_q[`CDO_PWR_EXTR]; // RULE_01
         DIST_RX_HF      <= pwr_q[`CDO_PWR_RXHF]; // RULE_02
         DIST_DEEP_SLEEP <= deep; // RULE_04
         // the sync pulse shows in the same cycle that the dividers stand cleared
         DIV_SYNC        <= div_sync_q;
      end
   end

   // register read
   // mode and divider reads pick the channel from the low address bits
   assign in_mode = (REG_ADDR >= `CDO_A_MODE0) && (REG_ADDR <= `CDO_A_MODE3);
   assign in_div  = (REG_ADDR >= `CDO_A_DIV0) && (REG_ADDR <= `CDO_A_DIVL);
   // divider block starts at channel field value 2
   assign rd_ch   = REG_ADDR[3:2] - `CDO_DIV_CH0;

   // unmapped addresses and the command register read as zero
   always @* begin
      rd_mode = mode_all[6*REG_ADDR[1:0] +: 6];
      rd_div  = div_all[30*rd_ch +: 30];
      rdata_d = 8'h00;
      if (REG_ADDR == `CDO_A_PWR) begin
         rdata_d = {2'h0, pwr_q};
      end else if (REG_ADDR == `CDO_A_ENA) begin
         rdata_d = {4'h0, ena_q};
      end else if (REG_ADDR == `CDO_A_SYNC) begin
         rdata_d = {2'h0, sync_q};
      end else if (REG_ADDR == `CDO_A_AUTO) begin
         rdata_d = {6'h00, auto_q};
      end else if (in_mode) begin
         rdata_d = {2'h0, rd_mode};
      end else if (in_div) begin
         if (REG_ADDR[1:0] == 2'h0) begin
            rdata_d = rd_div[7:0];
         end else if (REG_ADDR[1:0] == 2'h1) begin
            rdata_d = rd_div[15:8];
         end else if (REG_ADDR[1:0] == 2'h2) begin
            rdata_d = rd_div[23:16];
         end else begin
            rdata_d = {2'h0, rd_div[29:24]};
         end
      end else if (REG_ADDR == `CDO_A_STAT) begin
         // status: phase lock, frequency lock, deep sleep, sync pending
         rdata_d = {4'h0, phase_q, freq_q, deep, pend_q};
      end
   end

   always @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         REG_RDATA <= 8'h00;
      end else if (REG_RD) begin
         // read data stand one cycle after the strobe, zero otherwise
         REG_RDATA <= rdata_d;
      end else begin
         REG_RDATA <= 8'h00;
      end
   end

endmodule // cdo_dist_top

// ### sim/cdo_load.sv
`timescale 1ns/100ps

// downstream load: counts rising edges on a driven positive pin
module cdo_load (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        p_out,
   input  wire        p_oe,
   output reg  [15:0] edges_q
);
   reg last_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_q  <= 1'b0;
         edges_q <= 16'h0000;
      end else begin
         last_q <= p_out & p_oe;
         if (p_oe && p_out && !last_q) edges_q <= edges_q + 16'h0001;
      end
   end
endmodule // cdo_load

// ### sim/cdo_dist_props.sv
`timescale 1ns/100ps
`include "cdo_consts.vh"

module cdo_dist_props (
   input wire        CLK_SYS,
   input wire        RESET_N,
   input wire [15:0] REG_ADDR,
   input wire [7:0]  REG_WDATA,
   input wire        REG_WR,
   input wire        REG_RD,
   input wire [7:0]  REG_RDATA,
   input wire        LOOP_FREQ_LOCK,
   input wire        LOOP_PHASE_LOCK,
   input wire        REF_ACTIVE_EDGE,
   input wire        LOOP_FB_EDGE,
   input wire [3:0]  CH_P_OUT,
   input wire [3:0]  CH_P_OE,
   input wire [3:0]  CH_N_OUT,
   input wire [3:0]  CH_N_OE,
   input wire [3:0]  CH_PWRDN,
   input wire [3:0]  CH_LVDS,
   input wire [3:0]  CH_LVPECL,
   input wire        DIST_EXT_RSET,
   input wire        DIST_RX_HF,
   input wire        DIST_DEEP_SLEEP,
   input wire [3:0]  DIV_SYNC
);
   reg  [3:0] mask_q;
   reg  [1:0] src_q;
   reg  [1:0] auto_q;
   wire [3:0] diff = CH_LVDS | CH_LVPECL;
   wire       wr_sync = REG_WR && REG_ADDR == `CDO_A_SYNC;
   wire       wr_auto = REG_WR && REG_ADDR == `CDO_A_AUTO;
   wire       go_cmd = REG_WR && REG_ADDR == `CDO_A_CMD && REG_WDATA[0];

   // shadow of the sync fields; reserved codes keep the old value
   always @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         mask_q <= 4'h0;
         src_q  <= 2'h0;
         auto_q <= 2'h0;
      end else begin
         if (wr_sync) mask_q <= REG_WDATA[3:0];
         if (wr_sync && REG_WDATA[5:4] != 2'h3) src_q <= REG_WDATA[5:4];
         if (wr_auto && REG_WDATA[1:0] != 2'h3) auto_q <= REG_WDATA[1:0];
      end
   end

   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);

   rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
      else $error("read data outside its slot");
   power_fields_a: assert property (REG_WR && REG_ADDR == `CDO_A_PWR |->
      ##2 {DIST_EXT_RSET, DIST_RX_HF, CH_PWRDN} == $past(REG_WDATA[5:0], 2))
      else $error("power settings not on pins");
   deep_sleep_a: assert property (DIST_DEEP_SLEEP == (CH_PWRDN == 4'hF))
      else $error("deep sleep mismatch");
   pwrdn_off_a: assert property (CH_PWRDN == $past(CH_PWRDN) &&
      CH_PWRDN == $past(CH_PWRDN, 2) |-> ((CH_P_OE | CH_N_OE) & CH_PWRDN) == 4'h0)
      else $error("powered down channel drives");
   sync_mask_a: assert property (DIV_SYNC != 4'h0 |-> (DIV_SYNC & mask_q) == 4'h0)
      else $error("masked divider synced");
   sync_direct_a: assert property (go_cmd && src_q == 2'h0 |->
      ##1 (DIV_SYNC == 4'h0) [*2] ##1 DIV_SYNC == ~mask_q)
      else $error("direct sync wrong");
   sync_edge_a: assert property (DIV_SYNC != 4'h0 && src_q != 2'h0 |->
      (src_q == 2'h1 ? $past(REF_ACTIVE_EDGE, 2) : $past(LOOP_FB_EDGE, 2)))
      else $error("sync not aligned to source");
   auto_sync_a: assert property (src_q == 2'h0 &&
      (auto_q == 2'h1 && $rose(LOOP_FREQ_LOCK) || auto_q == 2'h2 && $rose(LOOP_PHASE_LOCK))
      |-> ##3 DIV_SYNC == ~mask_q)
      else $error("lock sync missing");
   diff_pair_a: assert property (diff == $past(diff) && diff == $past(diff, 2) |->
      (diff & CH_P_OE & CH_N_OE & ~(CH_P_OUT ^ CH_N_OUT)) == 4'h0)
      else $error("differential pair in phase");

   cover property (DIV_SYNC != 4'h0);
   cover property (DIST_DEEP_SLEEP);
   cover property (CH_LVDS != 4'h0);
endmodule // cdo_dist_props

bind cdo_dist_top cdo_dist_props cdo_dist_props_i (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
   .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
   .REG_RDATA(REG_RDATA), .LOOP_FREQ_LOCK(LOOP_FREQ_LOCK), .LOOP_PHASE_LOCK(LOOP_PHASE_LOCK),
   .REF_ACTIVE_EDGE(REF_ACTIVE_EDGE), .LOOP_FB_EDGE(LOOP_FB_EDGE), .CH_P_OUT(CH_P_OUT),
   .CH_P_OE(CH_P_OE), .CH_N_OUT(CH_N_OUT), .CH_N_OE(CH_N_OE), .CH_PWRDN(CH_PWRDN),
   .CH_LVDS(CH_LVDS), .CH_LVPECL(CH_LVPECL), .DIST_EXT_RSET(DIST_EXT_RSET),
   .DIST_RX_HF(DIST_RX_HF), .DIST_DEEP_SLEEP(DIST_DEEP_SLEEP), .DIV_SYNC(DIV_SYNC));

// ### sim/tb_cdo_dist_top.sv
`timescale 1ns/100ps
`include "cdo_consts.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
   $display("unexpected at %0t got %h exp %h", $time, (a), (e)); end end

module tb_cdo_dist_top;
   reg         CLK_SYS, RESET_N, REG_WR, REG_RD, REF_ACTIVE_EDGE, LOOP_FB_EDGE;
   reg         LOOP_FREQ_LOCK, LOOP_PHASE_LOCK;
   reg  [15:0] REG_ADDR;
   reg  [7:0]  REG_WDATA;
   wire [7:0]  REG_RDATA;
   wire [3:0]  CH_P_OUT, CH_P_OE, CH_N_OUT, CH_N_OE, CH_PWRDN, CH_DRIVE_HI, CH_LVDS, CH_LVPECL;
   wire [3:0]  DIV_SYNC;
   wire        DIST_EXT_RSET, DIST_RX_HF, DIST_DEEP_SLEEP;
   wire [15:0] edges [0:3];
   int         num_errors = 0, n_checks = 0, cyc = 0;

   cdo_dist_top cdo_dist_top_i (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
      .LOOP_FREQ_LOCK(LOOP_FREQ_LOCK), .LOOP_PHASE_LOCK(LOOP_PHASE_LOCK),
      .REF_ACTIVE_EDGE(REF_ACTIVE_EDGE), .LOOP_FB_EDGE(LOOP_FB_EDGE), .CH_P_OUT(CH_P_OUT),
      .CH_P_OE(CH_P_OE), .CH_N_OUT(CH_N_OUT), .CH_N_OE(CH_N_OE), .CH_PWRDN(CH_PWRDN),
      .CH_DRIVE_HI(CH_DRIVE_HI), .CH_LVDS(CH_LVDS), .CH_LVPECL(CH_LVPECL),
      .DIST_EXT_RSET(DIST_EXT_RSET), .DIST_RX_HF(DIST_RX_HF),
      .DIST_DEEP_SLEEP(DIST_DEEP_SLEEP), .DIV_SYNC(DIV_SYNC));

   for (genvar g = 0; g < 4; g++) begin : ld
      cdo_load cdo_load_i (.clk(CLK_SYS), .rst_n(RESET_N), .p_out(CH_P_OUT[g]),
         .p_oe(CH_P_OE[g]), .edges_q(edges[g]));
   end

   initial begin
      CLK_SYS = 1'b0;
      forever #20 CLK_SYS = ~CLK_SYS;
   end

   always @(posedge CLK_SYS) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         finish_test();
      end
   end

   task wr(input [15:0] a, input [7:0] d);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge CLK_SYS);
      REG_WR <= 1'b0;
      @(posedge CLK_SYS);
   endtask

   task rd(input [15:0] a, input [7:0] e);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge CLK_SYS);
      REG_RD <= 1'b0;
      // read data stand only in the cycle right after the strobe
      #1 `CHK(REG_RDATA, e)
      @(posedge CLK_SYS);
   endtask

   // catches the first sync pulse within eight cycles
   task wait_sync(input [3:0] e);
      logic [3:0] v;
      v = 4'h0;
      repeat (8) begin
         @(posedge CLK_SYS);
         #1 if (v == 4'h0) v = DIV_SYNC;
      end
      `CHK(v, e)
   endtask

   task pulse(input r);
      REF_ACTIVE_EDGE <= r;
      LOOP_FB_EDGE <= !r;
      @(posedge CLK_SYS);
      REF_ACTIVE_EDGE <= 1'b0;
      LOOP_FB_EDGE <= 1'b0;
   endtask

   function [23:0] exp4(input [5:0] x);
      for (int j = 0; j < 6; j++) exp4[4*j +: 4] = {4{x[j]}};
   endfunction

   task t_reset;
      for (int i = 0; i < 10; i++)
         rd(i < 9 ? 16'(16'h0400 + i) : 16'h0500, (i > 3 && i < 8) ? 8'h03 : 8'h00);
      `CHK(CH_P_OE | CH_N_OE, 4'h0)
      $display("reset test done");
   endtask

   task t_reserved;
      wr(`CDO_A_SYNC, 8'h31);
      rd(`CDO_A_SYNC, 8'h01);
      wr(`CDO_A_AUTO, 8'h03);
      rd(`CDO_A_AUTO, 8'h00);
      wr(`CDO_A_MODE0, 8'h1E);
      rd(`CDO_A_MODE0, 8'h1B);
      wr(`CDO_A_SYNC, 8'h00);
      wr(16'h040B, 8'hFF);
      rd(16'h040B, 8'h3F);
      $display("reserved test done");
   endtask

   task automatic t_pins;
      logic [7:0] m [8] = '{8'h00, 8'h10, 8'h30, 8'h3C, 8'h0D, 8'h11, 8'h02, 8'h03};
      logic [5:0] x [8] = '{6'h34, 6'h38, 6'h3C, 6'h3A, 6'h35, 6'h28, 6'h14, 6'h00};
      for (int c = 0; c < 4; c++) wr(16'(16'h040B + 4 * c), 8'h3F);
      wr(`CDO_A_ENA, 8'h0F);
      for (int i = 0; i < 8; i++) begin
         for (int c = 0; c < 4; c++) wr(16'(`CDO_A_MODE0 + c), m[i]);
         repeat (4) @(posedge CLK_SYS);
         #1 `CHK({CH_P_OE, CH_N_OE, CH_P_OUT, CH_N_OUT, CH_LVDS, CH_LVPECL}, exp4(x[i]))
         `CHK(CH_DRIVE_HI, {4{m[i][3]}})
      end
      $display("pin mode test done");
   endtask

   task automatic t_pwr;
      logic [7:0]  pw [4] = '{8'h05, 8'h3F, 8'h17, 8'h00};
      logic [7:0]  en [4] = '{8'h0F, 8'h0F, 8'h0F, 8'h07};
      logic [10:0] ex [4] = '{11'h05A, 11'h7F0, 11'h178, 11'h007};
      for (int c = 0; c < 4; c++) wr(16'(`CDO_A_MODE0 + c), 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(`CDO_A_PWR, pw[i]);
         wr(`CDO_A_ENA, en[i]);
         repeat (4) @(posedge CLK_SYS);
         #1 `CHK({DIST_DEEP_SLEEP, DIST_EXT_RSET, DIST_RX_HF, CH_PWRDN, CH_P_OE}, ex[i])
         if (i == 1) rd(`CDO_A_STAT, 8'h02);
      end
      $display("power test done");
   endtask

   task t_div;
      logic [15:0] e0;
      for (int i = 0; i < 2; i++) begin
         wr(`CDO_A_DIV0, i ? 8'h00 : 8'h03);
         wr(16'h040B, 8'h00);
         wr(`CDO_A_CMD, 8'h01);
         repeat (8) @(posedge CLK_SYS);
         #1 e0 = edges[0];
         repeat (60) @(posedge CLK_SYS);
         #1 `CHK(16'(edges[0] - e0), i ? 16'h001E : 16'h000A)
      end
      $display("divider test done");
   endtask

   task t_sync;
      wr(`CDO_A_SYNC, 8'h05);
      wr(`CDO_A_CMD, 8'h01);
      wait_sync(4'hA);
      for (int s = 1; s < 3; s++) begin
         wr(`CDO_A_SYNC, {2'h0, 2'(s), 4'h5});
         wr(`CDO_A_CMD, 8'h01);
         pulse(s == 2);
         wait_sync(4'h0);
         rd(`CDO_A_STAT, 8'h01);
         pulse(s == 1);
         wait_sync(4'hA);
      end
      wr(`CDO_A_SYNC, 8'h05);
      for (int a = 0; a < 3; a++) begin
         wr(`CDO_A_AUTO, 8'(a));
         LOOP_FREQ_LOCK <= a != 2;
         LOOP_PHASE_LOCK <= a == 2;
         wait_sync(a == 0 ? 4'h0 : 4'hA);
         LOOP_FREQ_LOCK <= 1'b0;
         LOOP_PHASE_LOCK <= 1'b0;
         @(posedge CLK_SYS);
      end
      $display("sync test done");
   endtask

   task finish_test;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      RESET_N = 1'b0;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      REG_ADDR = 16'h0000;
      REG_WDATA = 8'h00;
      LOOP_FREQ_LOCK = 1'b0;
      LOOP_PHASE_LOCK = 1'b0;
      REF_ACTIVE_EDGE = 1'b0;
      LOOP_FB_EDGE = 1'b0;
      repeat (6) @(posedge CLK_SYS);
      RESET_N <= 1'b1;
      @(posedge CLK_SYS);
      t_reset;
      t_reserved;
      t_pins;
      t_pwr;
      t_div;
      t_sync;
      finish_test;
   end
endmodule // tb_cdo_dist_top
